// ### inc/stap_pkg.sv
package stap_pkg;
    localparam int IR_WIDTH = 3;
    localparam int ID_WIDTH = 32;
    localparam int BSR_WIDTH = 8;
    localparam int PIN_WIDTH = 6;
    // Instruction codes, most significant bit on the left
    localparam logic [2:0] INSTR_EXTERNAL_TEST = 3'h0;
    localparam logic [2:0] INSTR_IDENTIFY = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_HIGHZ = 3'h2;
    localparam logic [2:0] INSTR_RESERVED_BYPASS_ALIAS_A = 3'h3;
    localparam logic [2:0] INSTR_SAMPLE_PRELOAD = 3'h4;
    localparam logic [2:0] INSTR_PRIVATE = 3'h5;
    localparam logic [2:0] INSTR_RESERVED_BYPASS_ALIAS_B = 3'h6;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
    // Identification fields; vendor value is arbitrary
    localparam int ID_PRESENCE_POS = 0;
    localparam int ID_VENDOR_LSB = 1;
    localparam int ID_VENDOR_MSB = 11;
    localparam logic [10:0] ID_VENDOR_CODE = 11'h0_2a5;
    localparam logic [19:0] ID_UNUSED_BITS = 20'h0_0000;
    localparam logic [31:0] ID_CODE = {ID_UNUSED_BITS, ID_VENDOR_CODE, 1'b1};
    // Boundary cells with no pin load this value
    localparam logic [1:0] BSR_PINLESS_DEFAULT = 2'h3;
    localparam int TLR_TMS_EDGES = 5;
    localparam int SCAN_INPUT_SETUP_TIME_NS = 10;
    localparam int SCAN_INPUT_HOLD_TIME_NS = 10;
    typedef enum logic [1:0] {SEL_BYPASS, SEL_IDENT, SEL_BOUNDARY} stap_sel_type;
endpackage

// ### design/stap_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module stap_sync2 (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_en,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else if (clock_en) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ### design/stap_fsm.sv
`timescale 1ns/1ns
`default_nettype none
module stap_fsm (
    input wire logic test_clock,
    input wire logic rst_n,
    input wire logic tms,
    output logic in_reset,
    output logic in_capture_dr,
    output logic in_shift_dr,
    output logic in_update_dr,
    output logic in_capture_ir,
    output logic in_shift_ir,
    output logic in_update_ir
);
    import stap_pkg::*;
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR,
        ST_EX2_IR, ST_UPD_IR
    } stap_state_type;
    stap_state_type state_r;
    stap_state_type state_nxt;
    always_comb begin
        case (state_r)
            ST_RESET: state_nxt = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SHF_DR;
            ST_SHF_DR: state_nxt = tms ? ST_EX1_DR : ST_SHF_DR;
            ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SHF_DR;
            ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_nxt = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SHF_IR;
            ST_SHF_IR: state_nxt = tms ? ST_EX1_IR : ST_SHF_IR;
            ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SHF_IR;
            ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            default: state_nxt = ST_RESET;
        endcase
    end
    // Five high samples reach reset from any state; power-up also resets
    always_ff @(posedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RESET; // RULE18
        end else begin
            state_r <= state_nxt; // RULE18 RULE19
        end
    end
    assign in_reset = (state_r == ST_RESET);
    assign in_capture_dr = (state_r == ST_CAP_DR);
    assign in_shift_dr = (state_r == ST_SHF_DR);
    assign in_update_dr = (state_r == ST_UPD_DR);
    assign in_capture_ir = (state_r == ST_CAP_IR);
    assign in_shift_ir = (state_r == ST_SHF_IR);
    assign in_update_ir = (state_r == ST_UPD_IR);
endmodule
`default_nettype wire

// ### design/stap_top.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1 - Capture loads fixed identification code
// RULE2 - Identification shifts out LSB first
// RULE3 - Code: unused, vendor, presence bit
// RULE4 - Capture-IR loads low bits 01
// RULE5 - Instruction register shifts in Shift-IR
// RULE6 - New instruction acts at Update-IR
// RULE7 - Code 111 selects bypass bit
// RULE8 - Sample/preload captures pins, pinless defaults
// RULE9 - Controller holds pins stable during capture
// RULE10 - Code 000 external test, pins unblocked
// RULE11 - External test drives cells at Update-IR
// RULE12 - External test captures pins at Capture-DR
// RULE13 - Identify loaded at power-up and reset
// RULE14 - Code 010 floats outputs, captures, scans
// RULE15 - Codes 011, 110 act as bypass
// RULE16 - Codes read MSB left, LSB right
// RULE17 - Instruction register three bits wide
// RULE18 - Five high mode samples reset controller
// RULE19 - Sample rising edge, drive falling edge
// RULE20 - Undriven mode or data reads one
// RULE21 - Code 101 acts as bypass
// RULE22 - Data out driven only when shifting
module stap_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_en,
    input wire logic test_clock,
    input wire logic tms,
    input wire logic tms_driven,
    input wire logic tdi,
    input wire logic tdi_driven,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [stap_pkg::PIN_WIDTH-1:0] mem_pins_in,
    input wire logic [stap_pkg::PIN_WIDTH-1:0] mem_core_out,
    input wire logic mem_core_oe,
    output logic [stap_pkg::PIN_WIDTH-1:0] mem_pins_out,
    output logic mem_pins_oe,
    output logic [2:0] active_instr
);
    import stap_pkg::*;

    function automatic stap_sel_type decode_sel(input logic [2:0] code);
        case (code) // RULE16
            INSTR_IDENTIFY: decode_sel = SEL_IDENT;
            INSTR_EXTERNAL_TEST, INSTR_SAMPLE_HIGHZ, INSTR_SAMPLE_PRELOAD:
                decode_sel = SEL_BOUNDARY;
            // Bypass, both reserved aliases and the private code
            default: decode_sel = SEL_BYPASS; // RULE7 RULE15 RULE21
        endcase
    endfunction

    // Undriven inputs resolve to one
    logic tms_eff;
    logic tdi_eff;
    assign tms_eff = tms_driven ? tms : 1'b1; // RULE20
    assign tdi_eff = tdi_driven ? tdi : 1'b1; // RULE20

    logic in_reset, in_capture_dr, in_shift_dr, in_update_dr;
    logic in_capture_ir, in_shift_ir, in_update_ir;
    stap_fsm u_fsm (
        .test_clock(test_clock),
        .rst_n(rst_n),
        .tms(tms_eff),
        .in_reset(in_reset),
        .in_capture_dr(in_capture_dr),
        .in_shift_dr(in_shift_dr),
        .in_update_dr(in_update_dr),
        .in_capture_ir(in_capture_ir),
        .in_shift_ir(in_shift_ir),
        .in_update_ir(in_update_ir)
    );

    logic [IR_WIDTH-1:0] ir_shift_r; // RULE17
    logic [IR_WIDTH-1:0] ir_active_r;
    logic [ID_WIDTH-1:0] id_r;
    logic bypass_r;
    logic [BSR_WIDTH-1:0] bsr_r;
    logic [PIN_WIDTH-1:0] bsr_update_r;
    logic tdo_r;
    logic tdo_oe_r;
    stap_sel_type sel;
    assign sel = decode_sel(ir_active_r);

    always_ff @(posedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift_r <= INSTR_IDENTIFY;
        end else if (in_capture_ir) begin
            ir_shift_r <= {ir_shift_r[IR_WIDTH-1:2], IR_CAPTURE_PATTERN}; // RULE4
        end else if (in_shift_ir) begin
            ir_shift_r <= {tdi_eff, ir_shift_r[IR_WIDTH-1:1]}; // RULE5 RULE19
        end
    end

    // Active instruction changes only on Update-IR or reset
    always_ff @(negedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            ir_active_r <= INSTR_IDENTIFY; // RULE13
        end else if (in_reset) begin
            ir_active_r <= INSTR_IDENTIFY; // RULE13
        end else if (in_update_ir) begin
            ir_active_r <= ir_shift_r; // RULE6
        end
    end

    always_ff @(posedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            id_r <= ID_CODE;
        end else if (sel == SEL_IDENT && in_capture_dr) begin
            id_r <= ID_CODE; // RULE1 RULE3
        end else if (sel == SEL_IDENT && in_shift_dr) begin
            id_r <= {tdi_eff, id_r[ID_WIDTH-1:1]}; // RULE2
        end
    end

    always_ff @(posedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            bypass_r <= 1'b0;
        end else if (sel == SEL_BYPASS && in_capture_dr) begin
            bypass_r <= 1'b0;
        end else if (sel == SEL_BYPASS && in_shift_dr) begin
            bypass_r <= tdi_eff; // RULE7
        end
    end

    // Pins captured in test clock domain through two flops
    logic [PIN_WIDTH-1:0] pins_sync;
    genvar gi;
    generate
        for (gi = 0; gi < PIN_WIDTH; gi++) begin : g_pin_sync
            stap_sync2 u_sync (
                .clock(test_clock),
                .rst_n(rst_n),
                .clock_en(1'b1),
                .async_in(mem_pins_in[gi]),
                .sync_out(pins_sync[gi])
            );
        end
    endgenerate

    always_ff @(posedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            bsr_r <= '0;
        end else if (sel == SEL_BOUNDARY && in_capture_dr) begin
            // Pins must be stable around capture; the controller ensures it
            bsr_r <= {BSR_PINLESS_DEFAULT, pins_sync}; // RULE8 RULE9 RULE12 RULE14
        end else if (sel == SEL_BOUNDARY && in_shift_dr) begin
            bsr_r <= {tdi_eff, bsr_r[BSR_WIDTH-1:1]}; // RULE14
        end
    end

    // Parallel boundary drive latched on falling edge
    always_ff @(negedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            bsr_update_r <= '0;
        end else if (in_update_ir || in_update_dr) begin
            bsr_update_r <= bsr_r[PIN_WIDTH-1:0]; // RULE11
        end
    end

    // Data out changes on falling edge, driven only in shift states
    always_ff @(negedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_oe_r <= in_shift_ir || in_shift_dr; // RULE22 RULE19
            if (in_shift_ir) begin
                tdo_r <= ir_shift_r[0];
            end else begin
                case (sel)
                    SEL_IDENT: tdo_r <= id_r[0];
                    SEL_BOUNDARY: tdo_r <= bsr_r[0];
                    default: tdo_r <= bypass_r;
                endcase
            end
        end
    end
    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;

    // Toggle marks each update and each reset that changes the instruction; both words stand still until the next one
    logic xfer_tog_r;
    always_ff @(negedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            xfer_tog_r <= 1'b0;
        end else if (in_update_ir || in_update_dr) begin
            xfer_tog_r <= !xfer_tog_r;
        end else if (in_reset && ir_active_r != INSTR_IDENTIFY) begin
            xfer_tog_r <= !xfer_tog_r;
        end
    end

    // Memory side reads the words only once the toggle has crossed
    // Updates closer than three memory clocks apart may be missed
    logic xfer_sync;
    logic xfer_seen_r;
    logic xfer_load;
    logic [PIN_WIDTH-1:0] pins_out_r;
    logic pins_oe_r;
    logic [IR_WIDTH-1:0] instr_r;
    logic [PIN_WIDTH-1:0] drive_r;
    logic [IR_WIDTH-1:0] instr_now;
    logic [PIN_WIDTH-1:0] drive_now;
    stap_sync2 u_xfer_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clock_en(clock_en),
        .async_in(xfer_tog_r),
        .sync_out(xfer_sync)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xfer_seen_r <= 1'b0;
        end else if (clock_en) begin
            xfer_seen_r <= xfer_sync;
        end
    end
    assign xfer_load = (xfer_sync != xfer_seen_r);
    assign instr_now = xfer_load ? ir_active_r : instr_r;
    assign drive_now = xfer_load ? bsr_update_r : drive_r;

    // Pins follow the core except in external test; high-z sample floats them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pins_out_r <= '0;
            pins_oe_r <= 1'b0;
            instr_r <= INSTR_IDENTIFY;
            drive_r <= '0;
        end else if (clock_en) begin
            instr_r <= instr_now;
            drive_r <= drive_now;
            if (instr_now == INSTR_EXTERNAL_TEST) begin
                pins_out_r <= drive_now; // RULE10 RULE11
                pins_oe_r <= 1'b1;
            end else if (instr_now == INSTR_SAMPLE_HIGHZ) begin
                pins_out_r <= mem_core_out;
                pins_oe_r <= 1'b0; // RULE14
            end else begin
                pins_out_r <= mem_core_out;
                pins_oe_r <= mem_core_oe;
            end
        end
    end
    assign mem_pins_out = pins_out_r;
    assign mem_pins_oe = pins_oe_r;
    assign active_instr = instr_r;
endmodule
`default_nettype wire

// ### tb/stap_sva.sv
`timescale 1ns/1ns
`default_nettype none
module stap_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic test_clock,
    input wire logic tms,
    input wire logic tms_driven,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [stap_pkg::PIN_WIDTH-1:0] mem_core_out,
    input wire logic mem_core_oe,
    input wire logic [stap_pkg::PIN_WIDTH-1:0] mem_pins_out,
    input wire logic mem_pins_oe,
    input wire logic [2:0] active_instr
);
    import stap_pkg::*;
    logic tdo_rise_r;
    // Data out as seen just before each rising test edge
    always_ff @(posedge test_clock or negedge rst_n) begin
        if (!rst_n) begin
            tdo_rise_r <= 1'b0;
        end else begin
            tdo_rise_r <= tdo;
        end
    end
    property p_instr_reset;
        @(posedge clock) disable iff (!rst_n) $rose(rst_n) |-> active_instr == INSTR_IDENTIFY;
    endproperty
    a_instr_reset: assert property (p_instr_reset) else $error("instr after reset");
    property p_highz;
        @(posedge clock) disable iff (!rst_n)
            (active_instr == INSTR_SAMPLE_HIGHZ)[*3] |-> !mem_pins_oe;
    endproperty
    a_highz: assert property (p_highz) else $error("pins driven in high-z");
    property p_extest_oe;
        @(posedge clock) disable iff (!rst_n)
            (active_instr == INSTR_EXTERNAL_TEST)[*3] |-> mem_pins_oe;
    endproperty
    a_extest_oe: assert property (p_extest_oe) else $error("pins idle in ext test");
    property p_core_pass;
        @(posedge clock) disable iff (!rst_n)
            (active_instr != INSTR_EXTERNAL_TEST && active_instr != INSTR_SAMPLE_HIGHZ)[*3]
            |-> mem_pins_out == $past(mem_core_out) && mem_pins_oe == $past(mem_core_oe);
    endproperty
    a_core_pass: assert property (p_core_pass) else $error("core values not passed");
    property p_oe_rise;
        @(posedge test_clock) disable iff (!rst_n)
            $rose(tdo_oe) |-> $past(tms_driven) && !$past(tms);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("data out enabled early");
    property p_oe_fall;
        @(posedge test_clock) disable iff (!rst_n)
            $fell(tdo_oe) |-> $past(tms) || !$past(tms_driven);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("data out released early");
    property p_tms_reset;
        @(posedge test_clock) disable iff (!rst_n) (tms || !tms_driven)[*5] |=> !tdo_oe;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("no reset on mode high");
    property p_tdo_edge;
        @(negedge test_clock) disable iff (!rst_n) tdo_oe |-> tdo == tdo_rise_r;
    endproperty
    a_tdo_edge: assert property (p_tdo_edge) else $error("data out moved on rise");
endmodule
bind stap_top stap_sva u_stap_sva (.clock(clock), .rst_n(rst_n), .test_clock(test_clock),
    .tms(tms), .tms_driven(tms_driven), .tdo(tdo), .tdo_oe(tdo_oe), .mem_core_out(mem_core_out),
    .mem_core_oe(mem_core_oe), .mem_pins_out(mem_pins_out), .mem_pins_oe(mem_pins_oe),
    .active_instr(active_instr));
`default_nettype wire

// ### tb/stap_host.sv
`timescale 1ns/1ns
`default_nettype none
module stap_host (
    output logic test_clock,
    output logic tms,
    output logic tms_driven,
    output logic tdi,
    output logic tdi_driven,
    input wire logic tdo
);
    initial begin
        test_clock = 1'b0;
        tms = 1'b1;
        tms_driven = 1'b1;
        tdi = 1'b1;
        tdi_driven = 1'b1;
    end
    // Clock stands low between steps; q is data out before the rise
    task automatic step(input logic m, input logic d, input logic drv, output logic q);
        #1;
        tms_driven = drv;
        tdi_driven = drv;
        tms = drv ? m : ~tms;
        tdi = drv ? d : ~tdi;
        q = tdo;
        #2 test_clock = 1'b1;
        #3 test_clock = 1'b0;
    endtask
    // Idle to shift, n bits LSB first, stop in pause
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, 1'b1, q);
        if (ir) begin
            step(1'b1, 1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, 1'b1, q);
        step(1'b0, 1'b1, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1, q);
            dout[i] = q;
        end
        step(1'b0, 1'b1, 1'b1, q);
    endtask
    // Pause, exit, update, idle
    task automatic update();
        logic q;
        step(1'b1, 1'b1, 1'b1, q);
        step(1'b1, 1'b1, 1'b1, q);
        step(1'b0, 1'b1, 1'b1, q);
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import stap_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic test_clock, tms, tms_driven, tdi, tdi_driven, tdo, tdo_oe, mem_pins_oe;
    logic mem_core_oe = 1'b0;
    logic clock_en = 1'b1;
    logic [PIN_WIDTH-1:0] pins_in = '0, core_out = '0, pins_out;
    logic [2:0] active_instr, prev;
    logic [31:0] seed = 32'h0000_3a44;
    logic [31:0] dout, din, last_din;
    logic [2:0] codes [8] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    int failures = 0;
    int samples_checked = 0;
    always #50 clock = ~clock;
    stap_top u_stap_top (.clock(clock), .rst_n(rst_n), .clock_en(clock_en),
        .test_clock(test_clock),
        .tms(tms), .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven), .tdo(tdo),
        .tdo_oe(tdo_oe), .mem_pins_in(pins_in), .mem_core_out(core_out),
        .mem_core_oe(mem_core_oe), .mem_pins_out(pins_out), .mem_pins_oe(mem_pins_oe),
        .active_instr(active_instr));
    stap_host u_host (.test_clock(test_clock), .tms(tms), .tms_driven(tms_driven), .tdi(tdi),
        .tdi_driven(tdi_driven), .tdo(tdo));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Data register seen after an 8-bit scan
    function automatic logic [7:0] exp_dr(logic [2:0] c, logic [7:0] d, logic [5:0] p);
        if (c == 3'h1) return ID_CODE[7:0];
        if (c == 3'h0 || c == 3'h2 || c == 3'h4) return {2'b11, p};
        return {d[6:0], 1'b0};
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_clk(int n);
        repeat (n) @(negedge clock);
    endtask
    initial begin
        #2_000_000;
        failures++;
        finish_test();
    end
    initial begin
        logic q;
        repeat (3) u_host.step(1'b1, 1'b1, 1'b1, q);
        wait_clk(12);
        rst_n = 1'b1;
        check(active_instr, 3'h1);
        u_host.step(1'b0, 1'b1, 1'b1, q);
        u_host.scan(1'b0, 32, rnd(), dout);
        u_host.update();
        check(dout, ID_CODE);
        prev = 3'h1;
        last_din = din;
        foreach (codes[k]) begin
            wait_clk(1);
            din = rnd();
            pins_in = din[5:0];
            core_out = din[13:8];
            mem_core_oe = din[16];
            u_host.scan(1'b1, 3, {29'h0, codes[k]}, dout);
            check(dout[1:0], 2'b01);
            wait_clk(5);
            check(active_instr, prev);
            u_host.update();
            wait_clk(5);
            check(active_instr, codes[k]);
            if (codes[k] == 3'h0) check({mem_pins_oe, pins_out}, {1'b1, last_din[5:0]});
            din = rnd();
            u_host.scan(1'b0, 8, din, dout);
            u_host.update();
            wait_clk(5);
            check(dout[7:0], exp_dr(codes[k], din[7:0], pins_in));
            if (codes[k] == 3'h2) check(mem_pins_oe, 1'b0);
            else if (codes[k] == 3'h0) check({mem_pins_oe, pins_out}, {1'b1, din[5:0]});
            else check({mem_pins_oe, pins_out}, {mem_core_oe, core_out});
            prev = codes[k];
            last_din = din;
            $display("test %0d done", k);
        end
        clock_en = 1'b0;
        repeat (5) u_host.step(1'b0, 1'b0, 1'b0, q);
        u_host.step(1'b0, 1'b1, 1'b1, q);
        wait_clk(5);
        check(active_instr, 3'h7);
        clock_en = 1'b1;
        wait_clk(5);
        check(active_instr, 3'h1);
        check(tdo_oe, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
